// *** hw/trr_consts.vh ***
// constants for the timer read resynchronisation block
`ifndef TRR_CONSTS_VH
`define TRR_CONSTS_VH

// sync interface control field positions and reset value
`define TRR_CTL_WIDTH 4
`define TRR_CTL_POSTED_BIT 2
`define TRR_CTL_READ_MODE_BIT 3
`define TRR_CTL_RESET 4'h0

// read select codes
`define TRR_SEL_COUNTER 2'h0
`define TRR_SEL_CAPTURE_ONE 2'h1
`define TRR_SEL_CAPTURE_TWO 2'h2
`define TRR_SEL_WATCHDOG 2'h3

// resynchroniser depth and watchdog wake wait
`define TRR_SYNC_STAGES 3
`define TRR_WAKE_IFACE_CYCLES 2
`define TRR_WAKE_FUNC_CYCLES 1

// functional clock divider and reset counts
`define TRR_FUNC_DIV 4
`define TRR_COUNT_RESET 32'h00000000
`define TRR_WDOG_RESET 32'h00000000

`endif

// *** hw/trr_resync_stage.v ***
// multi-stage resynchroniser for one value crossing to the interface side
`timescale 1ns/1ps
module trr_resync_stage #(
  parameter WIDTH = 32,
  parameter STAGES = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // stage advance while the interface clock runs
  input wire adv,
  // value in and settled value out
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] pipe_reg [0:STAGES-1];
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // shift chain; frozen while the interface clock is stopped
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      for (i = 0; i < STAGES; i = i + 1) begin
        pipe_reg[i] <= {WIDTH{1'b0}};
      end
    end else if (adv) begin
      pipe_reg[0] <= din;
      for (i = 1; i < STAGES; i = i + 1) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  assign dout = pipe_reg[STAGES-1];

endmodule // trr_resync_stage

// *** hw/trr_timer_read.v ***
// general timer and watchdog counters with resynchronised register reads
// Function
// - control bit 2 selects posted or non-posted
// - posted reads just after wake may be stale
// - non-posted reads after wake return current values
// - watchdog is posted only, no software switch
// - watchdog read right after wake may be stale
// - read-mode bit write-only on some timers, reads 0
`timescale 1ns/1ps
`include "trr_consts.vh"
module trr_timer_read #(
  parameter WIDTH = 32,
  parameter SYNC_STAGES = `TRR_SYNC_STAGES,
  parameter FUNC_DIV = `TRR_FUNC_DIV,
  parameter READ_MODE_WRITE_ONLY = 1'b0
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // interface clock running indication
  input wire iface_clk_on,
  // timer and watchdog control
  input wire timer_enable,
  input wire wdog_enable,
  input wire capture_one_evt,
  input wire capture_two_evt,
  // sync interface control write and read
  input wire ctl_wr_en,
  input wire [3:0] ctl_wr_data,
  output wire [3:0] ctl_rd_data,
  // value read request
  input wire rd_req,
  input wire [1:0] rd_sel,
  output wire rd_busy,
  output reg rd_valid_reg,
  output reg [WIDTH-1:0] rd_data_reg,
  output reg rd_stale_reg,
  // status
  output wire resync_settled,
  output wire wdog_read_ok
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  localparam [7:0] DIV_LAST = FUNC_DIV - 1;
  localparam [3:0] SETTLE_LAST = SYNC_STAGES;
  localparam [3:0] WAKE_IFACE = `TRR_WAKE_IFACE_CYCLES;
  localparam [3:0] WAKE_FUNC = `TRR_WAKE_FUNC_CYCLES;
  localparam [3:0] CTL_RESET = `TRR_CTL_RESET;

  reg [7:0] div_reg;
  reg func_tick_reg;
  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] cap_one_reg;
  reg [WIDTH-1:0] cap_two_reg;
  reg [WIDTH-1:0] wdog_reg;
  reg posted_reg;
  reg read_mode_reg;
  reg iface_on_d_reg;
  reg [3:0] settle_reg;
  reg [3:0] wake_iface_reg;
  reg [3:0] wake_func_reg;
  reg state_reg;
  reg state_next;
  reg [1:0] sel_reg;
  wire wake;
  wire [WIDTH-1:0] count_sync;
  wire [WIDTH-1:0] cap_one_sync;
  wire [WIDTH-1:0] cap_two_sync;
  wire [WIDTH-1:0] wdog_sync;
  wire nonposted;
  wire take;
  wire answer_now;
  reg [WIDTH-1:0] sel_value;
  reg [1:0] use_sel;

  ////////////////////////////////////////////////////////////////////////////
  // functional clock rate as an enable pulse
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      div_reg <= 8'h00;
      func_tick_reg <= 1'b0;
    end else begin
      func_tick_reg <= (div_reg == DIV_LAST);
      if (div_reg == DIV_LAST) begin
        div_reg <= 8'h00;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // functional domain counters and captures
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count_reg <= `TRR_COUNT_RESET;
      cap_one_reg <= `TRR_COUNT_RESET;
      cap_two_reg <= `TRR_COUNT_RESET;
      wdog_reg <= `TRR_WDOG_RESET;
    end else begin
      if (func_tick_reg && timer_enable) begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (capture_one_evt) begin
        cap_one_reg <= count_reg;
      end
      if (capture_two_evt) begin
        cap_two_reg <= count_reg;
      end
      if (func_tick_reg && wdog_enable) begin
        wdog_reg <= wdog_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync interface control
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      posted_reg <= CTL_RESET[`TRR_CTL_POSTED_BIT];
      read_mode_reg <= CTL_RESET[`TRR_CTL_READ_MODE_BIT];
    end else if (ctl_wr_en) begin
      posted_reg <= ctl_wr_data[`TRR_CTL_POSTED_BIT];
      read_mode_reg <= ctl_wr_data[`TRR_CTL_READ_MODE_BIT];
    end
  end

  // read-mode position reads zero on write-only variants
  assign ctl_rd_data = {read_mode_reg & ~READ_MODE_WRITE_ONLY,
                        posted_reg, 2'b00};
  // posted clear selects non-posted; read-mode set is software's part
  assign nonposted = ~posted_reg;

  ////////////////////////////////////////////////////////////////////////////
  // resynchronisers towards the interface side, advancing only while on
  trr_resync_stage #(.WIDTH(WIDTH), .STAGES(SYNC_STAGES)) u_sync_count (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .adv(iface_clk_on),
    .din(count_reg),
    .dout(count_sync)
  );
  trr_resync_stage #(.WIDTH(WIDTH), .STAGES(SYNC_STAGES)) u_sync_cap_one (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .adv(iface_clk_on),
    .din(cap_one_reg),
    .dout(cap_one_sync)
  );
  trr_resync_stage #(.WIDTH(WIDTH), .STAGES(SYNC_STAGES)) u_sync_cap_two (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .adv(iface_clk_on),
    .din(cap_two_reg),
    .dout(cap_two_sync)
  );
  trr_resync_stage #(.WIDTH(WIDTH), .STAGES(SYNC_STAGES)) u_sync_wdog (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .adv(iface_clk_on),
    .din(wdog_reg),
    .dout(wdog_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake tracking: stages refill and watchdog wait after stopped to active
  assign wake = iface_clk_on & ~iface_on_d_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      iface_on_d_reg <= 1'b0;
      settle_reg <= 4'h0;
      wake_iface_reg <= 4'h0;
      wake_func_reg <= 4'h0;
    end else begin
      iface_on_d_reg <= iface_clk_on;
      if (!iface_clk_on || wake) begin
        settle_reg <= 4'h0;
        wake_iface_reg <= 4'h0;
        wake_func_reg <= 4'h0;
      end else begin
        if (settle_reg != SETTLE_LAST) begin
          settle_reg <= settle_reg + 4'h1;
        end
        if (wake_iface_reg != WAKE_IFACE) begin
          wake_iface_reg <= wake_iface_reg + 4'h1;
        end
        if (func_tick_reg && wake_func_reg != WAKE_FUNC) begin
          wake_func_reg <= wake_func_reg + 4'h1;
        end
      end
    end
  end

  assign resync_settled = iface_clk_on && (settle_reg == SETTLE_LAST);
  assign wdog_read_ok = resync_settled && (wake_iface_reg == WAKE_IFACE) &&
                        (wake_func_reg == WAKE_FUNC);

  ////////////////////////////////////////////////////////////////////////////
  // read control: posted answers at once, non-posted waits for settling
  assign take = rd_req && iface_clk_on && (state_reg == ST_IDLE);
  // watchdog never takes the non-posted path
  assign answer_now = (rd_sel == `TRR_SEL_WATCHDOG) || !nonposted ||
                      resync_settled;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && !answer_now) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (resync_settled) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign rd_busy = (state_reg == ST_WAIT);

  always @* begin
    use_sel = (state_reg == ST_WAIT) ? sel_reg : rd_sel;
    case (use_sel)
      `TRR_SEL_COUNTER: sel_value = count_sync;
      `TRR_SEL_CAPTURE_ONE: sel_value = cap_one_sync;
      `TRR_SEL_CAPTURE_TWO: sel_value = cap_two_sync;
      default: sel_value = wdog_sync;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      sel_reg <= `TRR_SEL_COUNTER;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= {WIDTH{1'b0}};
      rd_stale_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rd_valid_reg <= 1'b0;
      if (take) begin
        sel_reg <= rd_sel;
      end
      if (take && answer_now) begin
        rd_valid_reg <= 1'b1;
        rd_data_reg <= sel_value;
        if (rd_sel == `TRR_SEL_WATCHDOG) begin
          rd_stale_reg <= ~wdog_read_ok;
        end else begin
          rd_stale_reg <= ~resync_settled;
        end
      end else if (state_reg == ST_WAIT && resync_settled) begin
        rd_valid_reg <= 1'b1;
        rd_data_reg <= sel_value;
        rd_stale_reg <= 1'b0;
      end
    end
  end

endmodule // trr_timer_read

// *** bench/trr_chk.sv ***
// assertion checker bound to the timer read resynchronisation block
`timescale 1ns/1ps
module trr_chk #(parameter READ_MODE_WRITE_ONLY = 1'b0) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // interface clock and control
  input wire iface_clk_on,
  input wire ctl_wr_en,
  input wire [3:0] ctl_wr_data,
  input wire [3:0] ctl_rd_data,
  // read path
  input wire rd_req,
  input wire [1:0] rd_sel,
  input wire rd_busy,
  input wire rd_valid_reg,
  input wire rd_stale_reg,
  // status
  input wire resync_settled,
  input wire wdog_read_ok
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire take = rd_req & iface_clk_on & ~rd_busy;
  wire wake_take = take & iface_clk_on;
  a_posted_bit: assert property (ctl_wr_en |=> ctl_rd_data[2] ==
    $past(ctl_wr_data[2]) && ctl_rd_data[1:0] == 2'h0)
    else $error("posted bit not stored");
  a_posted_answer: assert property (take && ctl_rd_data[2] |=>
    rd_valid_reg && !rd_busy) else $error("posted read late");
  a_wake_stale: assert property ($rose(iface_clk_on) && wake_take &&
    ctl_rd_data[2] |=> rd_stale_reg) else $error("wake read not flagged");
  a_nonposted_fresh: assert property (take && !ctl_rd_data[2] &&
    rd_sel != 2'h3 |=> ##[0:5] (rd_valid_reg && !rd_stale_reg))
    else $error("non-posted read not fresh");
  a_wdog_posted: assert property (take && rd_sel == 2'h3 |=>
    rd_valid_reg && !rd_busy) else $error("watchdog read not posted");
  a_wdog_wake: assert property ($rose(iface_clk_on) && take &&
    rd_sel == 2'h3 |=> rd_stale_reg) else $error("watchdog wake unflagged");
  a_wdog_ok_wait: assert property ($rose(iface_clk_on) |->
    !wdog_read_ok ##1 !wdog_read_ok) else $error("watchdog ok too early");
  a_read_mode: assert property (ctl_wr_en |=> ctl_rd_data[3] ==
    ($past(ctl_wr_data[3]) & !READ_MODE_WRITE_ONLY))
    else $error("read mode readback wrong");
  a_settle_gap: assert property ($rose(iface_clk_on) |->
    !resync_settled [*2]) else $error("settled too early");
  a_settle_off: assert property (!iface_clk_on |-> !resync_settled)
    else $error("settled while clock off");
endmodule // trr_chk

bind trr_timer_read trr_chk #(.READ_MODE_WRITE_ONLY(READ_MODE_WRITE_ONLY))
  u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .iface_clk_on(iface_clk_on),
  .ctl_wr_en(ctl_wr_en), .ctl_wr_data(ctl_wr_data),
  .ctl_rd_data(ctl_rd_data), .rd_req(rd_req), .rd_sel(rd_sel),
  .rd_busy(rd_busy), .rd_valid_reg(rd_valid_reg),
  .rd_stale_reg(rd_stale_reg), .resync_settled(resync_settled),
  .wdog_read_ok(wdog_read_ok));

// *** bench/testbench.sv ***
// self-checking bench for the timer read resynchronisation block
`timescale 1ns/1ps
`include "trr_consts.vh"
module testbench;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg iface_clk_on = 1'b0, timer_enable = 1'b0, wdog_enable = 1'b0;
  reg capture_one_evt = 1'b0, capture_two_evt = 1'b0, ctl_wr_en = 1'b0;
  reg [3:0] ctl_wr_data = 4'h0;
  reg rd_req = 1'b0;
  reg [1:0] rd_sel = 2'h0;
  wire [3:0] ctl_rd_data, wo_ctl;
  wire rd_busy, rd_valid_reg, rd_stale_reg, resync_settled, wdog_read_ok;
  wire [31:0] rd_data_reg;
  integer error_cnt = 0, checked = 0, cyc = 0, tc = 0, wc = 0, n, i;
  integer seed = 32'he38a1598;
  integer ev [0:3];
  reg [31:0] v;
  always #12.5 sys_clk = ~sys_clk;
  trr_timer_read u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .iface_clk_on(iface_clk_on), .timer_enable(timer_enable),
    .wdog_enable(wdog_enable), .capture_one_evt(capture_one_evt),
    .capture_two_evt(capture_two_evt), .ctl_wr_en(ctl_wr_en),
    .ctl_wr_data(ctl_wr_data), .ctl_rd_data(ctl_rd_data), .rd_req(rd_req),
    .rd_sel(rd_sel), .rd_busy(rd_busy), .rd_valid_reg(rd_valid_reg),
    .rd_data_reg(rd_data_reg), .rd_stale_reg(rd_stale_reg),
    .resync_settled(resync_settled), .wdog_read_ok(wdog_read_ok));
  // second timer whose read-mode bit is write-only
  trr_timer_read #(.READ_MODE_WRITE_ONLY(1'b1)) u_wo (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .iface_clk_on(iface_clk_on),
    .timer_enable(timer_enable), .wdog_enable(wdog_enable),
    .capture_one_evt(capture_one_evt), .capture_two_evt(capture_two_evt),
    .ctl_wr_en(ctl_wr_en), .ctl_wr_data(ctl_wr_data), .ctl_rd_data(wo_ctl),
    .rd_req(1'b0), .rd_sel(2'h0), .rd_busy(), .rd_valid_reg(),
    .rd_data_reg(), .rd_stale_reg(), .resync_settled(), .wdog_read_ok());
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (!sys_rst) begin
      tc = tc + timer_enable;
      wc = wc + wdog_enable;
    end
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // counter phase against the tick is unknown: allow one tick either way
  function [31:0] near(input [31:0] got, input integer e);
    near = (got + 1 >= e && got <= e + 1) ? got : e;
  endfunction
  task wr(input [3:0] d);
    begin
      @(posedge sys_clk);
      ctl_wr_en <= 1'b1;
      ctl_wr_data <= d;
      @(posedge sys_clk);
      ctl_wr_en <= 1'b0;
      @(negedge sys_clk);
      check({28'h0, ctl_rd_data}, {28'h0, d[3:2], 2'h0});
      check({28'h0, wo_ctl}, {29'h0, d[2], 2'h0});
    end
  endtask
  task rd(input [1:0] s, input wake);
    begin
      @(posedge sys_clk);
      if (wake) begin
        iface_clk_on <= 1'b0;
        repeat (5) @(posedge sys_clk);
      end
      iface_clk_on <= 1'b1;
      rd_req <= 1'b1;
      rd_sel <= s;
      @(posedge sys_clk);
      rd_req <= 1'b0;
      n = 0;
      do begin
        @(negedge sys_clk);
        n = n + 1;
      end while (rd_valid_reg !== 1'b1 && n < 12);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    iface_clk_on <= 1'b1;
    timer_enable <= 1'b1;
    wdog_enable <= 1'b1;
    @(negedge sys_clk);
    check({28'h0, ctl_rd_data}, 32'h0);
    repeat (120) @(posedge sys_clk);
    wdog_enable <= 1'b0;
    repeat (80) @(posedge sys_clk);
    timer_enable <= 1'b0;
    repeat (4) @(posedge sys_clk);
    capture_one_evt <= 1'b1;
    capture_two_evt <= 1'b1;
    @(posedge sys_clk);
    capture_one_evt <= 1'b0;
    capture_two_evt <= 1'b0;
    repeat (10) @(posedge sys_clk);
    ev[0] = tc / `TRR_FUNC_DIV;
    ev[1] = ev[0];
    ev[2] = ev[0];
    ev[3] = wc / `TRR_FUNC_DIV;
    // watchdog read after the documented wake wait is reliable
    iface_clk_on <= 1'b0;
    repeat (5) @(posedge sys_clk);
    iface_clk_on <= 1'b1;
    repeat (`TRR_WAKE_IFACE_CYCLES + `TRR_FUNC_DIV) @(posedge sys_clk);
    rd(2'h3, 1'b0);
    check(n, 1);
    check({31'h0, rd_stale_reg}, 32'h0);
    check(rd_data_reg, near(rd_data_reg, ev[3]));
    for (i = 0; i < 200; i = i + 1) begin
      v = $random(seed);
      wr(v[3:0]);
      rd(v[5:4], v[6]);
      if (v[2] || v[5:4] == 2'h3) begin
        check(n, 1);
        if (v[6]) check({31'h0, rd_stale_reg}, 32'h1);
      end else begin
        check(n, v[6] ? `TRR_SYNC_STAGES + 2 : 1);
        check({31'h0, rd_stale_reg}, 32'h0);
      end
      check(rd_data_reg, near(rd_data_reg, ev[v[5:4]]));
    end
    final_report;
  end
  task final_report;
    begin
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
endmodule // testbench
